// File: src/err_agg_pkg.sv
package err_agg_pkg;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // error byte geometry
  localparam int ERR_W = 16;
  localparam int RATE_W = 2;
  localparam int NUM_BOARDS = 8;
  localparam int MODE_W = 2;

  // fixed positions inside the common error byte
  localparam int BIT_TIME_STRING = 4;
  localparam int BIT_BOARD_FAULT = 12;
  localparam int BIT_BOARD_MISSING = 13;
  // bit 0 carries no error meaning and reads as zero
  localparam logic [ERR_W-1:0] ERR_USED_MASK = 16'hFFFE;

  // register indices
  localparam logic [ADDR_W-1:0] REG_ERR_BYTE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_RATE_LO = 4'h1;
  localparam logic [ADDR_W-1:0] REG_RATE_HI = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h3;
  localparam logic [ADDR_W-1:0] REG_BOARD_MODE = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h6;
  localparam logic [ADDR_W-1:0] REG_OUT_STATE = 4'h7;

  // config register fields
  localparam int CFG_DYNAMIC_BIT = 0;
  localparam int CFG_FRONT_EN_BIT = 1;
  localparam int CFG_W = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 2'h0;

  // interrupt status fields
  localparam int IRQ_W = 3;
  localparam int IRQ_MINOR_BIT = 0;
  localparam int IRQ_MAJOR_BIT = 1;
  localparam int IRQ_CLEAR_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // per-bit rating codes
  localparam logic [RATE_W-1:0] RATE_MASKED = 2'h0;
  localparam logic [RATE_W-1:0] RATE_MINOR = 2'h1;
  localparam logic [RATE_W-1:0] RATE_MAJOR = 2'h2;
  localparam logic [ERR_W*RATE_W-1:0] RATE_RESET = 32'h0000_0000;

  // per-board supervision modes
  localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
  localparam logic [MODE_W-1:0] MODE_IDLE = 2'h1;
  localparam logic [MODE_W-1:0] MODE_MONITOR = 2'h2;
  localparam logic [NUM_BOARDS*MODE_W-1:0] MODE_RESET = 16'h0000;

  // state shown on the error output lines, gray along none-minor-major
  typedef enum logic [1:0] {
    OUT_NONE = 2'b00,
    OUT_MINOR = 2'b01,
    OUT_MAJOR = 2'b11
  } out_state_e;

endpackage

// File: src/error_priority_aggregator.sv
`timescale 1ns/1ps

// What this block does
// - each error type owns one bit; all bits form the common error byte
// - every error bit carries a rating: masked, minor or major
// - common error output rises when any minor or major bit is active
// - display error indicator lights for any unmasked error, priority not shown
// - active error drives backplane logic output and isolated output together
// - a setting also routes the logic error output to the front connector
// - static form shows only error or no error, all treated as major
// - dynamic form gives distinct output states for minor and major
// - board faulty, absent or erroring sets bits chosen by its supervision mode
// - monitoring board: unrecognised or internal fault sets bits 12 and 13
// - idle board: unrecognised sets bit 13 only; internal faults set nothing
// - every error bit may be read at any time
// - a bit reads 1 while its condition exists, 0 otherwise
// - bad or missing master/slave time string sets bit 4
module error_priority_aggregator
  import err_agg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [err_agg_pkg::ADDR_W-1:0] addr,
  input wire logic [err_agg_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [err_agg_pkg::DATA_W-1:0] rd_data,
  input wire logic [err_agg_pkg::ERR_W-1:0] sys_err,
  input wire logic time_string_err,
  input wire logic [err_agg_pkg::NUM_BOARDS-1:0] board_missing,
  input wire logic [err_agg_pkg::NUM_BOARDS-1:0] board_fault,
  output logic [err_agg_pkg::ERR_W-1:0] common_error_byte,
  output logic common_err,
  output logic display_err_ind,
  output logic err_ttl_bp,
  output logic err_opto_bp,
  output logic err_ttl_front,
  output logic [1:0] err_state,
  output logic irq
);

  import err_agg_pkg::*;

  // software-facing state
  logic [CFG_W-1:0] cfg_r;
  logic [NUM_BOARDS*MODE_W-1:0] board_mode_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_status_nxt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [ERR_W*RATE_W-1:0] ratings;

  // error path state
  logic [ERR_W-1:0] err_byte_r;
  logic [ERR_W-1:0] err_byte_nxt;
  out_state_e out_state_r;
  out_state_e out_state_nxt;

  // returns the board mode field for one board
  function automatic logic [MODE_W-1:0] mode_of(input logic [NUM_BOARDS*MODE_W-1:0] modes,
                                                input int idx);
    mode_of = modes[idx*MODE_W +: MODE_W];
  endfunction

  // returns the rating code for one error bit
  function automatic logic [RATE_W-1:0] rate_of(input logic [ERR_W*RATE_W-1:0] rates, input int idx);
    rate_of = rates[idx*RATE_W +: RATE_W];
  endfunction

  // address decode
  wire wr_rate_lo = wr_en && (addr == REG_RATE_LO);
  wire wr_rate_hi = wr_en && (addr == REG_RATE_HI);
  wire wr_cfg = wr_en && (addr == REG_CONFIG);
  wire wr_mode = wr_en && (addr == REG_BOARD_MODE);
  wire wr_irq_status = wr_en && (addr == REG_IRQ_STATUS);
  wire wr_irq_mask = wr_en && (addr == REG_IRQ_MASK);
  wire cfg_dynamic = cfg_r[CFG_DYNAMIC_BIT];
  wire cfg_front_en = cfg_r[CFG_FRONT_EN_BIT];

  rating_table u_rating_table (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(wr_rate_lo || wr_rate_hi),
    .wr_hi(wr_rate_hi),
    .wr_data(wr_data),
    .rd_hi(addr == REG_RATE_HI),
    .rd_data(),
    .ratings(ratings)
  );

  // board supervision: which board conditions reach bits 12 and 13
  logic board_fault_any;
  logic board_missing_any;
  always_comb begin
    board_fault_any = 1'b0;
    board_missing_any = 1'b0;
    for (int b = 0; b < NUM_BOARDS; b++) begin
      case (mode_of(board_mode_r, b))
        MODE_MONITOR: begin
          if (board_missing[b] || board_fault[b]) begin
            board_fault_any = 1'b1;
            board_missing_any = 1'b1;
          end
        end
        MODE_IDLE: begin
          if (board_missing[b]) begin
            board_missing_any = 1'b1;
          end
        end
        default: begin
          // board not integrated: never supervised
        end
      endcase
    end
  end

  // assemble the common error byte from live conditions
  always_comb begin
    err_byte_nxt = sys_err & ERR_USED_MASK;
    err_byte_nxt[BIT_TIME_STRING] = time_string_err;
    err_byte_nxt[BIT_BOARD_FAULT] = board_fault_any;
    err_byte_nxt[BIT_BOARD_MISSING] = board_missing_any;
  end

  // level, not sticky: a bit follows its condition
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_byte_r <= '0;
    end else begin
      err_byte_r <= err_byte_nxt;
    end
  end

  // filter each bit through its rating
  logic any_minor;
  logic any_major;
  always_comb begin
    any_minor = 1'b0;
    any_major = 1'b0;
    for (int i = 0; i < ERR_W; i++) begin
      if (err_byte_r[i]) begin
        case (rate_of(ratings, i))
          RATE_MASKED: begin
            // masked bits reach no error output or output state; they still show in the error byte
          end
          RATE_MINOR: any_minor = 1'b1;
          RATE_MAJOR: any_major = 1'b1;
          default: any_major = 1'b1; // spare code rates as major, never lost
        endcase
      end
    end
  end

  wire any_err = any_minor || any_major;

  // output state: static folds minor into major, major wins when both
  always_comb begin
    if (!any_err) begin
      out_state_nxt = OUT_NONE;
    end else if (!cfg_dynamic || any_major) begin
      out_state_nxt = OUT_MAJOR;
    end else begin
      out_state_nxt = OUT_MINOR;
    end
  end

  // output state flop, one cycle behind the byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_state_r <= OUT_NONE;
    end else begin
      out_state_r <= out_state_nxt;
    end
  end

  // common output and indicator share one source, so they never disagree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      common_err <= 1'b0;
      display_err_ind <= 1'b0;
    end else begin
      common_err <= any_err;
      display_err_ind <= any_err;
    end
  end

  // backplane pair and front copy; only the front copy is gated by its setting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_ttl_bp <= 1'b0;
      err_opto_bp <= 1'b0;
      err_ttl_front <= 1'b0;
    end else begin
      err_ttl_bp <= any_err;
      err_opto_bp <= any_err;
      err_ttl_front <= any_err && cfg_front_en;
    end
  end

  assign err_state = out_state_r;
  assign common_error_byte = err_byte_r;

  // events: entry into each output state, judged one cycle ahead of the flop
  logic [IRQ_W-1:0] irq_events;
  always_comb begin
    irq_events = '0;
    if (out_state_nxt != out_state_r) begin
      case (out_state_nxt)
        OUT_MINOR: irq_events[IRQ_MINOR_BIT] = 1'b1;
        OUT_MAJOR: irq_events[IRQ_MAJOR_BIT] = 1'b1;
        OUT_NONE: irq_events[IRQ_CLEAR_BIT] = 1'b1;
        default: irq_events = '0;
      endcase
    end
  end

  wire [IRQ_W-1:0] irq_w1c = wr_irq_status ? wr_data[IRQ_W-1:0] : '0;

  // set beats clear so an event in the clearing cycle survives
  always_comb begin
    irq_status_nxt = (irq_status_r & ~irq_w1c) | irq_events;
  end

  // sticky status bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_r <= IRQ_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // built from the next status so the line rises with its status bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_nxt & irq_mask_r);
    end
  end

  // output form and front routing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= wr_data[CFG_W-1:0];
    end
  end

  // supervision mode of every board, two bits each
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      board_mode_r <= MODE_RESET;
    end else if (wr_mode) begin
      board_mode_r <= wr_data[NUM_BOARDS*MODE_W-1:0];
    end
  end

  // interrupt mask, same layout as the status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_r <= IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_r <= wr_data[IRQ_W-1:0];
    end
  end

  // zero-padded views of the narrow registers
  wire [DATA_W-1:0] cfg_word = {{(DATA_W-CFG_W){1'b0}}, cfg_r};
  wire [DATA_W-1:0] irq_status_word = {{(DATA_W-IRQ_W){1'b0}}, irq_status_r};
  wire [DATA_W-1:0] irq_mask_word = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
  wire [DATA_W-1:0] out_state_word = {{(DATA_W-$bits(out_state_e)){1'b0}}, out_state_r};
  // rating words taken from the table flops, so they fit the one-cycle read slot
  wire [DATA_W-1:0] rate_lo_word = ratings[DATA_W-1:0];
  wire [DATA_W-1:0] rate_hi_word = ratings[ERR_W*RATE_W-1:DATA_W];

  // read mux on the live index; unmapped indices read zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    case (addr)
      REG_ERR_BYTE: rd_mux = err_byte_r;
      REG_RATE_LO: rd_mux = rate_lo_word;
      REG_RATE_HI: rd_mux = rate_hi_word;
      REG_CONFIG: rd_mux = cfg_word;
      REG_BOARD_MODE: rd_mux = board_mode_r;
      REG_IRQ_STATUS: rd_mux = irq_status_word;
      REG_IRQ_MASK: rd_mux = irq_mask_word;
      REG_OUT_STATE: rd_mux = out_state_word;
      default: rd_mux = '0;
    endcase
  end

  // read data register: loaded by a read strobe, zero in every other cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_en ? rd_mux : '0;
    end
  end

endmodule

// File: src/rating_table.sv
`timescale 1ns/1ps

// holds the rating of every error bit; two words of eight ratings each
module rating_table
  import err_agg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic wr_hi,
  input wire logic [err_agg_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_hi,
  output logic [err_agg_pkg::DATA_W-1:0] rd_data,
  output logic [err_agg_pkg::ERR_W*err_agg_pkg::RATE_W-1:0] ratings
);

  logic [ERR_W*RATE_W-1:0] table_r;

  // one write port, ratings change only on software writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      table_r <= RATE_RESET;
    end else if (wr_en && wr_hi) begin
      table_r[ERR_W*RATE_W-1:DATA_W] <= wr_data;
    end else if (wr_en) begin
      table_r[DATA_W-1:0] <= wr_data;
    end
  end

  // read data from a register, ready one cycle after the request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_hi ? table_r[ERR_W*RATE_W-1:DATA_W] : table_r[DATA_W-1:0];
    end
  end

  assign ratings = table_r;

endmodule

// File: verification/err_agg_props.sv
`timescale 1ns/1ps

// passive watch on the aggregator pins
module err_agg_props
  import err_agg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rd_en,
  input wire logic [err_agg_pkg::DATA_W-1:0] rd_data,
  input wire logic [err_agg_pkg::ERR_W-1:0] sys_err,
  input wire logic time_string_err,
  input wire logic [err_agg_pkg::ERR_W-1:0] common_error_byte,
  input wire logic common_err,
  input wire logic display_err_ind,
  input wire logic err_ttl_bp,
  input wire logic err_opto_bp,
  input wire logic err_ttl_front,
  input wire logic [1:0] err_state,
  input wire logic irq
);
  import err_agg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // bits with no board or string source, bar bit 0, copy sys_err straight through
  localparam logic [15:0] PLAIN = 16'hCFEE;

  byte_follow_a: assert property ((common_error_byte & PLAIN) == ($past(sys_err) & PLAIN))
    else $error("error byte does not follow inputs");
  bit_zero_a: assert property (common_error_byte[0] == 1'b0)
    else $error("bit zero set");
  time_bit_a: assert property (common_error_byte[BIT_TIME_STRING] == $past(time_string_err))
    else $error("time string bit wrong");
  err_cause_a: assert property (common_err |-> $past(common_error_byte) != 16'h0000)
    else $error("common error without cause");
  err_clear_a: assert property (common_error_byte == 16'h0000 |=> !common_err)
    else $error("common error stuck");
  ind_same_a: assert property (display_err_ind == common_err)
    else $error("indicator differs from common error");
  bp_pair_a: assert property (err_ttl_bp == common_err && err_opto_bp == common_err)
    else $error("backplane outputs differ");
  front_gate_a: assert property (err_ttl_front |-> common_err)
    else $error("front output without error");
  state_link_a: assert property ((err_state != OUT_NONE) == common_err)
    else $error("output state disagrees with error");
  state_legal_a: assert property (err_state != 2'b10)
    else $error("illegal output state");
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
    else $error("read data outside read slot");

  minor_c: cover property (err_state == OUT_MINOR);
  major_c: cover property (err_state == OUT_MAJOR);
  front_c: cover property (err_ttl_front);
  irq_c: cover property (irq);
endmodule

// File: verification/standby_switch.sv
`timescale 1ns/1ps

// redundancy switch: swaps to the standby source only while the output state is major
module standby_switch
  import err_agg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] err_state,
  output logic take_over
);
  import err_agg_pkg::*;
  // only the major code counts, so minor errors keep the active source in dynamic form but swap in static form
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      take_over <= 1'b0;
    end else begin
      take_over <= (err_state == OUT_MAJOR);
    end
  end
endmodule

// File: verification/tb_error_priority_aggregator.sv
`timescale 1ns/1ps

module tb_error_priority_aggregator;
  import err_agg_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic [15:0] sys_err = 16'h0000;
  logic time_string_err = 1'b0;
  logic [7:0] board_missing = 8'h00;
  logic [7:0] board_fault = 8'h00;
  logic [15:0] common_error_byte;
  logic common_err, display_err_ind, err_ttl_bp, err_opto_bp, err_ttl_front, irq, take_over;
  logic [1:0] err_state;
  int error_cnt = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;

  error_priority_aggregator DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .sys_err(sys_err), .time_string_err(time_string_err),
    .board_missing(board_missing), .board_fault(board_fault), .common_error_byte(common_error_byte),
    .common_err(common_err), .display_err_ind(display_err_ind), .err_ttl_bp(err_ttl_bp),
    .err_opto_bp(err_opto_bp), .err_ttl_front(err_ttl_front), .err_state(err_state), .irq(irq));
  standby_switch u_sw (.clk(clk), .rst_b(rst_b), .err_state(err_state), .take_over(take_over));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data only stands in the cycle after the strobe
  task automatic rchk(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(n, e, rd_data);
    @(posedge clk);
  endtask

  // four edges: byte, outputs, then the switch model; returns on an edge so callers drive there
  task automatic pins(input logic [7:0] e);
    repeat (4) @(posedge clk);
    #1 chk("pins", {8'h00, e}, {8'h00, common_err, display_err_ind, err_ttl_bp, err_opto_bp, err_ttl_front,
      take_over, err_state});
    @(posedge clk);
  endtask

  task automatic t_regs;
    rchk("config", REG_CONFIG, 16'h0000);
    rchk("rate_lo", REG_RATE_LO, 16'h0000);
    wr(REG_ERR_BYTE, 16'hFFFF);
    wr(4'hF, 16'hFFFF);
    rchk("byte_ro", REG_ERR_BYTE, 16'h0000);
    rchk("unmapped", 4'hF, 16'h0000);
  endtask

  task automatic t_rate;
    sys_err <= 16'h0002;
    pins(8'h00);
    rchk("byte", REG_ERR_BYTE, 16'h0002);
    wr(REG_RATE_LO, 16'h0004);
    pins(8'hF7);
    wr(REG_CONFIG, 16'h0001);
    pins(8'hF1);
    wr(REG_RATE_HI, 16'h0008);
    sys_err <= 16'h0202;
    pins(8'hF7);
    rchk("rate_hi", REG_RATE_HI, 16'h0008);
    wr(REG_CONFIG, 16'h0003);
    pins(8'hFF);
    wr(REG_RATE_HI, 16'h0000);
    wr(REG_RATE_LO, 16'h000C);
    pins(8'hFF);
    sys_err <= 16'h0000;
    pins(8'h00);
  endtask

  task automatic bstep(input logic [7:0] m, input logic [7:0] f, input logic [15:0] e);
    board_missing <= m;
    board_fault <= f;
    time_string_err <= e[4];
    pins(8'h00);
    rchk("byte", REG_ERR_BYTE, e);
    chk("byte_pin", e, common_error_byte);
  endtask

  // board 0 monitored, board 1 idle, board 2 off
  task automatic t_board;
    wr(REG_BOARD_MODE, 16'h0006);
    rchk("mode", REG_BOARD_MODE, 16'h0006);
    bstep(8'h00, 8'h00, 16'h0010);
    bstep(8'h00, 8'h01, 16'h3000);
    bstep(8'h00, 8'h02, 16'h0000);
    bstep(8'h02, 8'h00, 16'h2000);
    bstep(8'h01, 8'h00, 16'h3000);
    bstep(8'h04, 8'h04, 16'h0000);
  endtask

  task automatic t_irq;
    wr(REG_IRQ_STATUS, 16'h0007);
    wr(REG_IRQ_MASK, 16'h0003);
    wr(REG_RATE_LO, 16'h0004);
    sys_err <= 16'h0002;
    pins(8'hF9);
    chk("irq", 16'h0001, {15'h0000, irq});
    rchk("state", REG_OUT_STATE, 16'h0001);
    rchk("mask", REG_IRQ_MASK, 16'h0003);
    rchk("status", REG_IRQ_STATUS, 16'h0001);
    wr(REG_IRQ_STATUS, 16'h0001);
    sys_err <= 16'h0000;
    pins(8'h00);
    chk("irq", 16'h0000, {15'h0000, irq});
    rchk("status", REG_IRQ_STATUS, 16'h0004);
  endtask

  task automatic final_report;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_rate();
    t_board();
    t_irq();
    final_report();
  end

  // whole run is well under a thousand cycles
  initial begin
    #100us;
    error_cnt++;
    final_report();
  end
endmodule

bind error_priority_aggregator err_agg_props u_props (.clk(clk), .rst_b(rst_b), .rd_en(rd_en),
  .rd_data(rd_data), .sys_err(sys_err), .time_string_err(time_string_err),
  .common_error_byte(common_error_byte), .common_err(common_err), .display_err_ind(display_err_ind),
  .err_ttl_bp(err_ttl_bp), .err_opto_bp(err_opto_bp), .err_ttl_front(err_ttl_front),
  .err_state(err_state), .irq(irq));
